// *** usdbm_pkg.sv ***
// Shared constants and carrier types of the UART auxiliary control block.
// Assumes one 100 MHz system clock and an active-low asynchronous reset.
package usdbm_pkg;

    // ************************************************************
    // Constants
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TIMEOUT_CHARS = 4;
    localparam logic [1:0] PRESC_DIV4_LAST = 2'h3;
    localparam logic [5:0] SR_FAST = 6'h04;
    localparam logic [5:0] SR_MID = 6'h08;
    localparam logic [5:0] SR_BASE = 6'h10;
    localparam logic [15:0] DIV_OFF = 16'h0000;
    localparam logic [2:0] LCR_FORCE_PAR0 = 3'h7;
    localparam logic TX_REQ_N_RST = 1'b0;
    localparam logic RX_REQ_N_RST = 1'b1;
    localparam logic LINE_IDLE = 1'b1;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic {PWR_AWAKE, PWR_ASLEEP} usdbm_pwr_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic parity;
        logic perr;
    } usdbm_rxchar_t;

    typedef struct packed {
        logic enable;
        logic auto_addr;
        logic [2:0] lcr_par;
        logic host_rx_en;
        logic [7:0] match_char;
    } usdbm_md_cfg_t;

    typedef struct packed {
        logic [1:0] presc_cnt;
        logic [15:0] div_cnt;
        logic [5:0] samp_cnt;
        logic samp_tick;
        logic bit_tick;
    } usdbm_baud_st_t;

    typedef struct packed {
        usdbm_rxchar_t push;
        logic lsr_irq;
        logic auto_en;
        logic host_prev;
        logic rx_en;
    } usdbm_filt_st_t;

    typedef struct packed {
        usdbm_pwr_t pwr;
        logic clk_en;
        logic rx_prev;
        logic [3:0] modem_prev;
        logic tx_req_n;
        logic rx_req_n;
        logic [5:0] to_cnt;
        logic timeout_irq;
        logic [4:0] brk_cnt;
        logic break_det;
        logic tx_line;
        logic dir_pend;
        logic dir;
    } usdbm_state_t;

endpackage

// *** usdbm_baud_gen.sv ***
// Baud generator: prescaler, 16-bit divisor and sample-rate counter.
// Assumes its run input is low while the channel clock is stopped.
`timescale 1ns/10ps
module usdbm_baud_gen (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_run,
    input wire logic i_presc4,
    input wire logic [15:0] i_divisor,
    input wire logic [5:0] i_sample_rate,
    output logic o_samp_tick,
    output logic o_bit_tick
);
    usdbm_pkg::usdbm_baud_st_t st_r, st_nxt;
    logic presc_tick;

    always_comb begin
        st_nxt = st_r;
        st_nxt.samp_tick = 1'b0;
        st_nxt.bit_tick = 1'b0;
        presc_tick = 1'b0;
        if (i_run && i_divisor != usdbm_pkg::DIV_OFF) begin
            if (i_presc4) begin
                presc_tick = (st_r.presc_cnt == usdbm_pkg::PRESC_DIV4_LAST);
                st_nxt.presc_cnt = st_r.presc_cnt + 2'h1;
            end else begin
                presc_tick = 1'b1;
                st_nxt.presc_cnt = 2'h0;
            end
            if (presc_tick) begin
                if (st_r.div_cnt == 16'h0000) begin
                    st_nxt.div_cnt = i_divisor - 16'h0001;
                    st_nxt.samp_tick = 1'b1;
                    if (st_r.samp_cnt + 6'h01 >= i_sample_rate) begin
                        st_nxt.samp_cnt = 6'h00;
                        st_nxt.bit_tick = 1'b1;
                    end else begin
                        st_nxt.samp_cnt = st_r.samp_cnt + 6'h01;
                    end
                end else begin
                    st_nxt.div_cnt = st_r.div_cnt - 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_samp_tick = st_r.samp_tick;
    assign o_bit_tick = st_r.bit_tick;

    no_div_tick_a: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        i_divisor == usdbm_pkg::DIV_OFF |=> !o_samp_tick)
        else $error("Baud tick with zero divisor");
endmodule // usdbm_baud_gen

// *** usdbm_addr_filter.sv ***
// Multidrop receive filter: decides which received bytes reach the RX FIFO.
// Assumes one received byte per valid pulse with its ninth (parity) bit.
`timescale 1ns/10ps
module usdbm_addr_filter (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input usdbm_pkg::usdbm_rxchar_t i_char,
    input usdbm_pkg::usdbm_md_cfg_t i_cfg,
    output usdbm_pkg::usdbm_rxchar_t o_push,
    output logic o_lsr_irq,
    output logic o_rx_enabled
);
    usdbm_pkg::usdbm_filt_st_t st_r, st_nxt;
    logic is_addr, match, normal_md, auto_md, rx_en;

    always_comb begin
        st_nxt = st_r;
        st_nxt.push = '0;
        st_nxt.lsr_irq = 1'b0;
        st_nxt.host_prev = i_cfg.host_rx_en;
        is_addr = i_char.parity;
        match = (i_char.data == i_cfg.match_char);
        auto_md = i_cfg.enable && i_cfg.auto_addr;
        normal_md = i_cfg.enable && !i_cfg.auto_addr
            && i_cfg.lcr_par == usdbm_pkg::LCR_FORCE_PAR0;
        rx_en = auto_md ? st_r.auto_en : i_cfg.host_rx_en;
        // Host turning its enable off ends the automatic session too
        if (st_r.host_prev && !i_cfg.host_rx_en) begin
            st_nxt.auto_en = 1'b0;
        end
        if (i_char.valid) begin
            if (auto_md) begin
                if (is_addr && match) begin
                    st_nxt.auto_en = 1'b1;
                    st_nxt.push = i_char;
                    st_nxt.push.perr = i_char.parity;
                    st_nxt.lsr_irq = 1'b1;
                end else if (is_addr) begin
                    st_nxt.auto_en = 1'b0;
                end else if (rx_en) begin
                    st_nxt.push = i_char;
                    st_nxt.push.perr = 1'b0;
                end
            end else if (normal_md) begin
                if (is_addr) begin
                    st_nxt.push = i_char;
                    st_nxt.push.perr = 1'b1;
                    st_nxt.lsr_irq = 1'b1;
                end else if (rx_en) begin
                    st_nxt.push = i_char;
                end
            end else begin
                st_nxt.push = i_char;
                st_nxt.lsr_irq = i_char.perr;
            end
        end
        // Registered so the effective enable leaves the block from a flop
        st_nxt.rx_en = auto_md ? st_nxt.auto_en : i_cfg.host_rx_en;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_push = st_r.push;
    assign o_lsr_irq = st_r.lsr_irq;
    assign o_rx_enabled = st_r.rx_en;

    nomatch_drop_a: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        i_char.valid && i_cfg.enable && i_cfg.auto_addr && i_char.parity
        && i_char.data != i_cfg.match_char |=> !o_push.valid && !st_r.auto_en)
        else $error("Unmatched address not dropped");
    addr_flag_a: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        i_char.valid && i_cfg.enable && !i_cfg.auto_addr && i_char.parity
        && i_cfg.lcr_par == usdbm_pkg::LCR_FORCE_PAR0
        |=> o_push.valid && o_push.perr && o_lsr_irq)
        else $error("Address byte not flagged");
endmodule // usdbm_addr_filter

// *** usdbm_top.sv ***
// Auxiliary control of one UART channel: sleep, DMA requests, receive
// time-out, break, baud generation and RS-485 direction / multidrop.
// Assumes the FIFOs, shifters and interrupt logic sit outside and report
// their state on plain ports, all synchronous to I_CLK_SYS.
`timescale 1ns/10ps
module usdbm_top (
    input wire logic I_CLK_SYS,
    input wire logic I_RESET_N,
    input wire logic I_EFR_ENHANCED,
    input wire logic I_EFR_SPECIAL,
    input wire logic I_IER_SLEEP,
    input wire logic I_FCR_FIFO_EN,
    input wire logic I_FCR_DMA_MODE,
    input wire logic I_LCR_BREAK,
    input wire logic [2:0] I_LCR_PARITY,
    input wire logic I_MCR_PRESCALE4,
    input wire logic [7:0] I_DIV_HIGH,
    input wire logic [7:0] I_DIV_LOW,
    input wire logic I_DLD_SR4,
    input wire logic I_DLD_SR8,
    input wire logic I_DLD_AUTO_DIR,
    input wire logic [3:0] I_SAMPLE_ADJ_A,
    input wire logic [3:0] I_SAMPLE_ADJ_B,
    input wire logic I_MD_ENABLE,
    input wire logic I_MD_INVERT,
    input wire logic [7:0] I_MATCH_CHAR,
    input wire logic I_HOST_RX_EN,
    input wire logic I_RX_LINE,
    input wire logic [3:0] I_MODEM,
    input wire logic I_TX_FIFO_EMPTY,
    input wire logic I_TSR_EMPTY,
    input wire logic I_TX_FULL,
    input wire logic [6:0] I_TX_SPACE,
    input wire logic [6:0] I_TX_TRIG,
    input wire logic I_IRQ_OTHER,
    input wire logic I_RX_FIFO_EMPTY,
    input wire logic [6:0] I_RX_LEVEL,
    input wire logic [6:0] I_RX_TRIG,
    input wire logic I_LSR_ERR,
    input wire logic I_THR_WRITE,
    input wire logic I_RHR_READ,
    input wire logic [3:0] I_CHAR_BITS,
    input wire logic I_RX_STOP_MID,
    input wire logic I_RX_VALID,
    input wire logic [7:0] I_RX_DATA,
    input wire logic I_RX_PARITY,
    input wire logic I_RX_PERR,
    input wire logic I_TX_SERIAL,
    input wire logic I_TX_DONE,
    input wire logic I_RTS_MANUAL,
    output logic O_SLEEP,
    output logic O_CLK_EN,
    output logic O_TX_DMA_REQ_N,
    output logic O_RX_DMA_REQ_N,
    output logic O_TIMEOUT_IRQ,
    output logic O_BREAK_DET,
    output logic O_TX_LINE,
    output logic O_DIR,
    output logic O_SAMPLE_TICK,
    output logic O_BIT_TICK,
    output logic O_PUSH_VALID,
    output logic [7:0] O_PUSH_DATA,
    output logic O_PUSH_PERR,
    output logic O_LSR_IRQ,
    output logic O_RX_ENABLED
);
    usdbm_pkg::usdbm_state_t st_r, st_nxt;
    usdbm_pkg::usdbm_rxchar_t rx_in, rx_push;
    usdbm_pkg::usdbm_md_cfg_t md_cfg;
    logic samp_tick, bit_tick, lsr_irq, rx_enabled;
    logic single_mode, sleep_ok, idle_ok, wake_evt;
    logic [5:0] sample_rate, to_limit;
    logic [4:0] brk_limit;

    // ************************************************************
    // Baud generation
    // ************************************************************
    always_comb begin
        if (I_DLD_SR4) begin
            sample_rate = usdbm_pkg::SR_FAST;
        end else if (I_DLD_SR8) begin
            sample_rate = usdbm_pkg::SR_MID;
        end else begin
            sample_rate = usdbm_pkg::SR_BASE - {2'h0, I_SAMPLE_ADJ_A}
                + {2'h0, I_SAMPLE_ADJ_B};
        end
    end

    // The generator stalls with the channel clock; the host must not touch
    // the divisor then, so no resynchronisation on wake is attempted.
    usdbm_baud_gen usdbm_baud_gen_inst (
        .i_clk(I_CLK_SYS),
        .i_reset_n(I_RESET_N),
        .i_run(st_r.clk_en),
        .i_presc4(I_MCR_PRESCALE4),
        .i_divisor({I_DIV_HIGH, I_DIV_LOW}),
        .i_sample_rate(sample_rate),
        .o_samp_tick(samp_tick),
        .o_bit_tick(bit_tick)
    );

    // ************************************************************
    // Multidrop filter
    // ************************************************************
    always_comb begin
        rx_in.valid = I_RX_VALID;
        rx_in.data = I_RX_DATA;
        rx_in.parity = I_RX_PARITY;
        rx_in.perr = I_RX_PERR;
        md_cfg.enable = I_MD_ENABLE;
        md_cfg.auto_addr = I_EFR_SPECIAL;
        md_cfg.lcr_par = I_LCR_PARITY;
        md_cfg.host_rx_en = I_HOST_RX_EN;
        md_cfg.match_char = I_MATCH_CHAR;
    end

    usdbm_addr_filter usdbm_addr_filter_inst (
        .i_clk(I_CLK_SYS),
        .i_reset_n(I_RESET_N),
        .i_char(rx_in),
        .i_cfg(md_cfg),
        .o_push(rx_push),
        .o_lsr_irq(lsr_irq),
        .o_rx_enabled(rx_enabled)
    );

    // ************************************************************
    // Control state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        single_mode = !I_FCR_FIFO_EN || !I_FCR_DMA_MODE;
        sleep_ok = I_EFR_ENHANCED && I_IER_SLEEP;
        idle_ok = I_RX_LINE == usdbm_pkg::LINE_IDLE && I_TX_FIFO_EMPTY
            && I_TSR_EMPTY && !I_IRQ_OTHER && I_RX_FIFO_EMPTY
            && I_MODEM == st_r.modem_prev;
        wake_evt = I_RX_LINE != st_r.rx_prev || I_MODEM != st_r.modem_prev
            || I_THR_WRITE;
        to_limit = 6'(usdbm_pkg::TIMEOUT_CHARS) * {2'h0, I_CHAR_BITS};
        brk_limit = {1'b0, I_CHAR_BITS};
        st_nxt.rx_prev = I_RX_LINE;
        st_nxt.modem_prev = I_MODEM;

        // Sleep: one awake cycle is forced after any wake event
        case (st_r.pwr)
            usdbm_pkg::PWR_AWAKE: begin
                if (sleep_ok && idle_ok && !wake_evt) begin
                    st_nxt.pwr = usdbm_pkg::PWR_ASLEEP;
                end
            end
            usdbm_pkg::PWR_ASLEEP: begin
                if (wake_evt || !sleep_ok) begin
                    st_nxt.pwr = usdbm_pkg::PWR_AWAKE;
                end
            end
            default: st_nxt.pwr = usdbm_pkg::PWR_AWAKE;
        endcase
        st_nxt.clk_en = st_nxt.pwr == usdbm_pkg::PWR_AWAKE;

        // Transmit DMA request
        if (single_mode) begin
            if (I_THR_WRITE) begin
                st_nxt.tx_req_n = 1'b1;
            end else if (I_TX_FIFO_EMPTY) begin
                st_nxt.tx_req_n = 1'b0;
            end
        end else begin
            if (I_TX_FULL) begin
                st_nxt.tx_req_n = 1'b1;
            end else if (I_TX_SPACE >= I_TX_TRIG) begin
                st_nxt.tx_req_n = 1'b0;
            end
        end

        // Receive time-out: counts bit times, parks at the limit
        if (I_RX_STOP_MID || I_RHR_READ) begin
            st_nxt.to_cnt = 6'h00;
        end else if (bit_tick && st_r.to_cnt < to_limit) begin
            st_nxt.to_cnt = st_r.to_cnt + 6'h01;
        end
        if (I_RHR_READ) begin
            st_nxt.timeout_irq = 1'b0;
        end
        // Set beats clear when both land in one cycle
        if (bit_tick && st_r.to_cnt + 6'h01 == to_limit && !I_RX_FIFO_EMPTY
            && I_RX_LEVEL < I_RX_TRIG) begin
            st_nxt.timeout_irq = 1'b1;
        end

        // Receive DMA request; release wins over assert
        if (single_mode) begin
            st_nxt.rx_req_n = I_RX_FIFO_EMPTY;
        end else if (I_RX_FIFO_EMPTY || I_LSR_ERR) begin
            st_nxt.rx_req_n = 1'b1;
        end else if (I_RX_LEVEL >= I_RX_TRIG || st_r.timeout_irq) begin
            st_nxt.rx_req_n = 1'b0;
        end

        // Break detection on the receive line
        if (I_RX_LINE) begin
            st_nxt.brk_cnt = 5'h00;
            st_nxt.break_det = 1'b0;
        end else if (bit_tick) begin
            if (st_r.brk_cnt > brk_limit) begin
                st_nxt.break_det = 1'b1;
            end else begin
                st_nxt.brk_cnt = st_r.brk_cnt + 5'h01;
            end
        end

        // Transmit line and direction control
        st_nxt.tx_line = I_LCR_BREAK ? 1'b0 : I_TX_SERIAL;
        if (I_THR_WRITE) begin
            st_nxt.dir_pend = 1'b1;
        end else if (I_TX_DONE && I_TX_FIFO_EMPTY) begin
            st_nxt.dir_pend = 1'b0;
        end
        if (I_DLD_AUTO_DIR) begin
            st_nxt.dir = st_nxt.dir_pend ^ I_MD_INVERT;
        end else begin
            st_nxt.dir = I_RTS_MANUAL;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st_r <= '0;
            st_r.pwr <= usdbm_pkg::PWR_AWAKE;
            st_r.clk_en <= 1'b1;
            st_r.rx_prev <= usdbm_pkg::LINE_IDLE;
            st_r.tx_req_n <= usdbm_pkg::TX_REQ_N_RST;
            st_r.rx_req_n <= usdbm_pkg::RX_REQ_N_RST;
            st_r.tx_line <= usdbm_pkg::LINE_IDLE;
            st_r.dir <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign O_SLEEP = st_r.pwr == usdbm_pkg::PWR_ASLEEP;
    assign O_CLK_EN = st_r.clk_en;
    assign O_TX_DMA_REQ_N = st_r.tx_req_n;
    assign O_RX_DMA_REQ_N = st_r.rx_req_n;
    assign O_TIMEOUT_IRQ = st_r.timeout_irq;
    assign O_BREAK_DET = st_r.break_det;
    assign O_TX_LINE = st_r.tx_line;
    assign O_DIR = st_r.dir;
    assign O_SAMPLE_TICK = samp_tick;
    assign O_BIT_TICK = bit_tick;
    assign O_PUSH_VALID = rx_push.valid;
    assign O_PUSH_DATA = rx_push.data;
    assign O_PUSH_PERR = rx_push.perr;
    assign O_LSR_IRQ = lsr_irq;
    assign O_RX_ENABLED = rx_enabled;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESET_N);

    sleep_gate_a: assert property ($rose(O_SLEEP) |-> $past(sleep_ok))
        else $error("Sleep entered without enables");
    sleep_idle_a: assert property ($rose(O_SLEEP)
        |-> $past(I_RX_FIFO_EMPTY && I_TX_FIFO_EMPTY && I_TSR_EMPTY
        && !I_IRQ_OTHER))
        else $error("Sleep entered while busy");
    wake_write_a: assert property (O_SLEEP && I_THR_WRITE
        |=> !O_SLEEP && O_CLK_EN)
        else $error("No wake on transmit write");
    wake_modem_a: assert property (O_SLEEP
        && I_MODEM != $past(I_MODEM) |=> !O_SLEEP)
        else $error("No wake on modem change");
    clk_stop_a: assert property (O_SLEEP |-> !O_CLK_EN)
        else $error("Clock running while asleep");
    tx_single_a: assert property (single_mode && I_THR_WRITE
        |=> O_TX_DMA_REQ_N)
        else $error("TX request kept after load");
    rx_single_a: assert property (single_mode
        |=> O_RX_DMA_REQ_N == $past(I_RX_FIFO_EMPTY))
        else $error("RX request does not track holding");
    tx_block_a: assert property (!single_mode && I_TX_FULL
        |=> O_TX_DMA_REQ_N)
        else $error("TX request active with full FIFO");
    tx_space_req_a: assert property (!single_mode && !I_TX_FULL
        && I_TX_SPACE >= I_TX_TRIG |=> !O_TX_DMA_REQ_N)
        else $error("TX request missing at space trigger");
    rx_block_a: assert property (!single_mode
        && (I_RX_FIFO_EMPTY || I_LSR_ERR) |=> O_RX_DMA_REQ_N)
        else $error("RX request not released");
    rx_tout_req_a: assert property (!single_mode && O_TIMEOUT_IRQ
        && !I_RX_FIFO_EMPTY && !I_LSR_ERR |=> !O_RX_DMA_REQ_N)
        else $error("RX request missing on time-out");
    timeout_set_a: assert property ($rose(O_TIMEOUT_IRQ)
        |-> $past(st_r.to_cnt) + 6'h01 == $past(to_limit))
        else $error("Time-out at wrong count");
    timeout_rst_a: assert property (I_RX_STOP_MID
        |=> st_r.to_cnt == 6'h00)
        else $error("Time-out count not restarted");
    break_low_a: assert property ($rose(O_BREAK_DET)
        |-> $past(!I_RX_LINE) && $past(!I_RX_LINE, 2))
        else $error("Break flagged without low line");
    break_tx_a: assert property (I_LCR_BREAK |=> !O_TX_LINE)
        else $error("Break not driven");
    dir_auto_a: assert property (I_DLD_AUTO_DIR && I_THR_WRITE
        && !I_MD_INVERT ##1 I_DLD_AUTO_DIR && !I_MD_INVERT |-> O_DIR)
        else $error("Direction not raised on write");
    dir_inv_a: assert property (I_DLD_AUTO_DIR && I_THR_WRITE
        && I_MD_INVERT ##1 I_DLD_AUTO_DIR && I_MD_INVERT |-> !O_DIR)
        else $error("Inverted direction wrong");

    sleep_c: cover property ($rose(O_SLEEP) ##[1:20] $fell(O_SLEEP));
    timeout_c: cover property ($rose(O_TIMEOUT_IRQ));
    break_c: cover property ($rose(O_BREAK_DET));
    dma_c: cover property ($fell(O_RX_DMA_REQ_N));
endmodule // usdbm_top

// *** usdbm_remote_station.sv ***
// Remote serial station: drives the receive line and received bytes.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/10ps
module usdbm_remote_station (
    input wire logic i_clk,
    output logic o_line,
    output usdbm_pkg::usdbm_rxchar_t o_char,
    output logic o_stop_mid
);
    // ********
    // Driver
    // ********
    initial begin
        o_line = 1'h1;
        o_char = '0;
        o_stop_mid = 1'h0;
    end

    task automatic level(input logic v);
        @(posedge i_clk);
        #1;
        o_line = v;
    endtask

    // Short start bit only; the byte appears at mid stop bit
    task automatic send(input logic [7:0] d, input logic p);
        level(1'h0);
        level(1'h1);
        o_stop_mid = 1'h1;
        o_char = {1'h1, d, p, 1'h0};
        @(posedge i_clk);
        #1;
        o_stop_mid = 1'h0;
        // Stale fields inverted so a late sample cannot match by luck
        o_char = {1'h0, ~d, ~p, 1'h1};
    endtask
endmodule // usdbm_remote_station

// *** usdbm_top_tb.sv ***
// Self-checking bench for the UART auxiliary control block.
// Assumes the remote station model drives the receive side.
`timescale 1ns/10ps
module usdbm_top_tb;
    logic I_CLK_SYS, I_RESET_N, I_EFR_ENHANCED, I_EFR_SPECIAL, I_IER_SLEEP;
    logic I_FCR_FIFO_EN, I_FCR_DMA_MODE, I_LCR_BREAK, I_MCR_PRESCALE4;
    logic I_DLD_SR4, I_DLD_SR8, I_DLD_AUTO_DIR, I_MD_ENABLE, I_MD_INVERT;
    logic I_HOST_RX_EN, I_TX_FIFO_EMPTY, I_TSR_EMPTY, I_TX_FULL, I_IRQ_OTHER;
    logic I_RX_FIFO_EMPTY, I_LSR_ERR, I_THR_WRITE, I_RHR_READ, I_TX_SERIAL;
    logic I_TX_DONE, I_RTS_MANUAL, I_RX_LINE, I_RX_STOP_MID;
    logic [2:0] I_LCR_PARITY;
    logic [3:0] I_SAMPLE_ADJ_A, I_SAMPLE_ADJ_B, I_MODEM, I_CHAR_BITS;
    logic [6:0] I_TX_SPACE, I_TX_TRIG, I_RX_LEVEL, I_RX_TRIG;
    logic [7:0] I_DIV_HIGH, I_DIV_LOW, I_MATCH_CHAR, O_PUSH_DATA, s, b;
    logic O_SLEEP, O_CLK_EN, O_TX_DMA_REQ_N, O_RX_DMA_REQ_N, O_TIMEOUT_IRQ;
    logic O_BREAK_DET, O_TX_LINE, O_DIR, O_SAMPLE_TICK, O_BIT_TICK;
    logic O_PUSH_VALID, O_PUSH_PERR, O_LSR_IRQ, O_RX_ENABLED;
    usdbm_pkg::usdbm_rxchar_t rx_char;
    wire I_RX_VALID = rx_char.valid;
    wire [7:0] I_RX_DATA = rx_char.data;
    wire I_RX_PARITY = rx_char.parity;
    wire I_RX_PERR = rx_char.perr;
    int bad_count, n_checks, cyc;

    usdbm_top usdbm_top_inst (.*);
    usdbm_remote_station usdbm_remote_station_inst (.i_clk(I_CLK_SYS),
        .o_line(I_RX_LINE), .o_char(rx_char), .o_stop_mid(I_RX_STOP_MID));

    // ********
    // Tasks
    // ********
    always #5 I_CLK_SYS = ~I_CLK_SYS;

    always @(posedge I_CLK_SYS) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            summarize;
        end
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic tk(input int n);
        repeat (n) begin
            @(posedge I_CLK_SYS);
            #1;
        end
    endtask

    task automatic tx_hold_reg;
        I_THR_WRITE = 1'h1;
        tk(1);
        I_THR_WRITE = 1'h0;
    endtask

    // Settle first: a rate change may leave a counter past its new end
    task automatic cnt(input int n);
        tk(80);
        s = 8'h00;
        b = 8'h00;
        repeat (n) begin
            tk(1);
            s = s + O_SAMPLE_TICK;
            b = b + O_BIT_TICK;
        end
    endtask

    task automatic md(input logic [7:0] d, input logic p, input logic [2:0] e);
        usdbm_remote_station_inst.send(d, p);
        chk(O_PUSH_VALID, e[2]);
        chk(O_LSR_IRQ, e[2] & e[1]);
        chk(O_RX_ENABLED, e[0]);
        if (e[2])
            chk({O_PUSH_DATA, O_PUSH_PERR}, {d, e[1]});
    endtask

    // ********
    // Scenarios
    // ********
    initial begin
        {I_CLK_SYS, I_RESET_N, I_EFR_ENHANCED, I_EFR_SPECIAL, I_IER_SLEEP,
         I_FCR_FIFO_EN, I_FCR_DMA_MODE, I_LCR_BREAK, I_MCR_PRESCALE4,
         I_DLD_SR4, I_DLD_SR8, I_DLD_AUTO_DIR, I_MD_ENABLE, I_MD_INVERT,
         I_HOST_RX_EN, I_TX_FULL, I_IRQ_OTHER, I_LSR_ERR, I_THR_WRITE,
         I_RHR_READ, I_TX_SERIAL, I_TX_DONE, I_RTS_MANUAL, I_LCR_PARITY,
         I_SAMPLE_ADJ_A, I_SAMPLE_ADJ_B, I_MODEM, I_TX_SPACE, I_TX_TRIG,
         I_RX_LEVEL, I_DIV_HIGH, I_DIV_LOW, I_MATCH_CHAR, I_TX_FIFO_EMPTY,
         I_TSR_EMPTY, I_RX_FIFO_EMPTY} = 3'h7;
        I_CHAR_BITS = 4'ha;
        I_RX_TRIG = 7'h08;
        tk(3);
        chk({O_SLEEP, O_CLK_EN, O_TX_DMA_REQ_N, O_RX_DMA_REQ_N, O_TX_LINE,
             O_DIR}, 8'h17);
        I_RESET_N = 1'h1;
        cnt(40);
        chk(s, 8'h00);
        I_DIV_LOW = 8'h03;
        cnt(60);
        chk(s, 8'h14);
        I_MCR_PRESCALE4 = 1'h1;
        cnt(120);
        chk(s, 8'h0a);
        {I_MCR_PRESCALE4, I_DIV_LOW, I_DLD_SR4} = 10'h003;
        cnt(240);
        chk(b, 8'h3c);
        {I_DLD_SR4, I_DLD_SR8} = 2'h1;
        cnt(240);
        chk(b, 8'h1e);
        {I_DLD_SR8, I_SAMPLE_ADJ_A, I_SAMPLE_ADJ_B} = 9'h062;
        cnt(240);
        chk(b, 8'h14);
        {I_DLD_SR4, I_FCR_FIFO_EN, I_FCR_DMA_MODE} = 3'h7;
        tk(2);
        {I_RX_FIFO_EMPTY, I_RX_LEVEL, I_RHR_READ} = 9'h003;
        tk(1);
        I_RHR_READ = 1'h0;
        tk(150);
        chk({O_TIMEOUT_IRQ, O_RX_DMA_REQ_N}, 8'h01);
        tk(25);
        chk({O_TIMEOUT_IRQ, O_RX_DMA_REQ_N}, 8'h02);
        I_LSR_ERR = 1'h1;
        tk(1);
        chk(O_RX_DMA_REQ_N, 8'h01);
        {I_FCR_DMA_MODE, I_LSR_ERR} = 2'h0;
        tk(2);
        chk(O_RX_DMA_REQ_N, 8'h00);
        I_RX_FIFO_EMPTY = 1'h1;
        tk(2);
        chk(O_RX_DMA_REQ_N, 8'h01);
        I_TX_FIFO_EMPTY = 1'h0;
        tx_hold_reg;
        chk(O_TX_DMA_REQ_N, 8'h01);
        I_TX_FIFO_EMPTY = 1'h1;
        tk(1);
        chk(O_TX_DMA_REQ_N, 8'h00);
        {I_FCR_DMA_MODE, I_TX_TRIG, I_TX_SPACE, I_TX_FULL} = 16'h9011;
        tk(1);
        chk(O_TX_DMA_REQ_N, 8'h01);
        I_TX_FULL = 1'h0;
        tk(2);
        chk(O_TX_DMA_REQ_N, 8'h01);
        I_TX_SPACE = 7'h10;
        tk(1);
        chk(O_TX_DMA_REQ_N, 8'h00);
        usdbm_remote_station_inst.level(1'h0);
        tk(40);
        chk(O_BREAK_DET, 8'h00);
        tk(25);
        chk(O_BREAK_DET, 8'h01);
        usdbm_remote_station_inst.level(1'h1);
        tk(1);
        chk(O_BREAK_DET, 8'h00);
        {I_LCR_BREAK, I_TX_SERIAL} = 2'h3;
        tk(1);
        chk(O_TX_LINE, 8'h00);
        I_LCR_BREAK = 1'h0;
        tk(1);
        chk(O_TX_LINE, 8'h01);
        {I_DLD_AUTO_DIR, I_TX_FIFO_EMPTY} = 2'h2;
        tx_hold_reg;
        chk(O_DIR, 8'h01);
        {I_TX_FIFO_EMPTY, I_TX_DONE} = 2'h3;
        tk(1);
        I_TX_DONE = 1'h0;
        chk(O_DIR, 8'h00);
        I_MD_INVERT = 1'h1;
        tk(1);
        chk(O_DIR, 8'h01);
        tx_hold_reg;
        chk(O_DIR, 8'h00);
        {I_MD_ENABLE, I_LCR_PARITY} = 4'hf;
        md(8'h5a, 1'h1, 3'h6);
        md(8'h33, 1'h0, 3'h0);
        I_HOST_RX_EN = 1'h1;
        md(8'h44, 1'h0, 3'h5);
        {I_HOST_RX_EN, I_EFR_SPECIAL, I_MATCH_CHAR} = 10'h0c3;
        tk(1);
        I_EFR_SPECIAL = 1'h1;
        md(8'h11, 1'h0, 3'h0);
        md(8'h12, 1'h1, 3'h0);
        md(8'hc3, 1'h1, 3'h7);
        md(8'h21, 1'h0, 3'h5);
        md(8'h55, 1'h1, 3'h0);
        I_EFR_ENHANCED = 1'h1;
        tk(4);
        chk(O_SLEEP, 8'h00);
        I_IER_SLEEP = 1'h1;
        tk(2);
        chk({O_SLEEP, O_CLK_EN}, 8'h02);
        {I_IRQ_OTHER, I_MODEM} = 5'h11;
        tk(1);
        chk(O_SLEEP, 8'h00);
        tk(3);
        chk(O_SLEEP, 8'h00);
        I_IRQ_OTHER = 1'h0;
        tk(3);
        chk(O_SLEEP, 8'h01);
        tx_hold_reg;
        chk(O_SLEEP, 8'h00);
        summarize;
    end
endmodule // usdbm_top_tb
